//--- logic/ltg_host_ctrl.v
// Host controller that programs the tone mode bits and drives the keying input
// Notes on behaviour
// (RQ1) Both mode bits high: device follows an external 22 kHz square wave on key input.
// (RQ2) External bit low, enable high: key input is an envelope gating internal tone.
// (RQ3) Continuous tone: hold key input high and external bit low.
// (RQ4) External mode: frequency and duty come from the applied 22 kHz wave.
// (RQ5) Set both bits to one before applying any external square wave.
// (RQ6) Device starts tone about 1 us after detecting the square wave.
// (RQ7) Device stops tone about 60 us after the square wave ceases.
// (RQ8) Device disables everything while supply is below the 4.7 V lockout.
// (RQ9) Device soft-start ramp takes about 4 ms from zero to 18 V.
// (RQ10) Envelope mode: tone is driven while the key input stays high.
// (RQ11) Envelope mode: tone starts about 6 us after rise, stops 15 to 60 us after.
// (RQ12) Enable bit low keeps the tone off whatever the key input does.
// (RQ13) Both bits read zero after power-on or lockout until configured.
`timescale 1ns/1ps
`include "ltg_regs.vh"
module ltg_host_ctrl #(
   parameter HALF_CYC = `LTG_HALF_CYC,
   parameter TAIL_CYC = `LTG_TAIL_CYC
) (
   input wire clk,
   input wire sys_rst,
   input wire [1:0] modeReq,
   input wire modeLoad,
   input wire burstOn,
   input wire underVoltage,
   output wire busy,
   output reg externalWaveformSelect,
   output reg toneEnableBit,
   output reg toneKeyInput
);
   localparam [15:0] SETUP_W = `LTG_SETUP_CYC;
   localparam [15:0] TAIL_W = TAIL_CYC;
   localparam ST_IDLE = 2'h0;
   localparam ST_SETUP = 2'h1;
   localparam ST_RUN = 2'h2;
   localparam ST_TAIL = 2'h3;

   reg [1:0] uvSync_r;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [1:0] mode_r;
   reg [15:0] wait_r;
   reg [15:0] wait_nxt;
   reg sqPhase_r;
   reg sqPhase_nxt;
   reg [1:0] mode_nxt;
   reg extSel_nxt;
   reg toneEn_nxt;
   reg key_nxt;
   wire halfTick;
   wire lockout;
   wire extRun;

   // Supply monitor is asynchronous to clk
   // Resets high so the first edges after reset still count as lockout
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         uvSync_r <= 2'h3;
      end else begin
         uvSync_r <= {uvSync_r[0], underVoltage};
      end
   end
   assign lockout = uvSync_r[1];

   assign extRun = (mode_r == `LTG_MODE_EXT) && (state_r == ST_RUN);
   assign busy = (state_r != ST_IDLE);

   // Half-period tick only while the wave runs
   ltg_divider #(
      .DIV(HALF_CYC)
   ) u_div (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(extRun),
      .tick(halfTick)
   );

   // RQ13 mode bits cleared at lockout
   always @* begin
      mode_nxt = mode_r;
      extSel_nxt = externalWaveformSelect;
      toneEn_nxt = toneEnableBit;
      if (lockout) begin
         // RQ8 nothing programmed during lockout
         mode_nxt = `LTG_MODE_OFF;
         extSel_nxt = 1'b0;
         toneEn_nxt = 1'b0;
      end else if (modeLoad && state_r == ST_IDLE) begin
         mode_nxt = modeReq;
         // RQ1 RQ2 RQ3 bit encoding per mode
         extSel_nxt = (modeReq == `LTG_MODE_EXT);
         // RQ12 enable bit low in off mode
         toneEn_nxt = (modeReq != `LTG_MODE_OFF);
      end
   end

   // RQ13 mode bits cleared at reset
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_r <= `LTG_MODE_OFF;
         externalWaveformSelect <= 1'b0;
         toneEnableBit <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         externalWaveformSelect <= extSel_nxt;
         toneEnableBit <= toneEn_nxt;
      end
   end

   always @* begin
      state_nxt = state_r;
      wait_nxt = wait_r;
      case (state_r)
         ST_IDLE: begin
            if (burstOn && mode_r != `LTG_MODE_OFF && !lockout) begin
               // RQ5 bits settle before keying starts
               state_nxt = ST_SETUP;
               wait_nxt = SETUP_W;
            end
         end
         ST_SETUP: begin
            if (wait_r == 16'h0001) begin
               state_nxt = ST_RUN;
            end else begin
               wait_nxt = wait_r - 16'h0001;
            end
         end
         ST_RUN: begin
            if (lockout) begin
               state_nxt = ST_TAIL;
               wait_nxt = TAIL_W;
            end else if (!burstOn && (mode_r != `LTG_MODE_EXT || (halfTick && sqPhase_r))) begin
               // RQ7 RQ11 wait out the device stop delay
               // Wave ends after a full high half so no runt pulse reaches the key
               state_nxt = ST_TAIL;
               wait_nxt = TAIL_W;
            end
         end
         default: begin
            if (wait_r == 16'h0001) begin
               state_nxt = ST_IDLE;
            end else begin
               wait_nxt = wait_r - 16'h0001;
            end
         end
      endcase
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wait_r <= 16'h0000;
      end else begin
         wait_r <= wait_nxt;
      end
   end

   always @* begin
      sqPhase_nxt = sqPhase_r;
      if (!extRun) begin
         sqPhase_nxt = 1'b0;
      end else if (halfTick) begin
         sqPhase_nxt = ~sqPhase_r;
      end
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sqPhase_r <= 1'b0;
      end else begin
         sqPhase_r <= sqPhase_nxt;
      end
   end

   // Next level for the key pin
   always @* begin
      key_nxt = 1'b0;
      case (mode_r)
         `LTG_MODE_CONT: begin
            // RQ3 key held high for continuous tone
            key_nxt = !lockout;
         end
         `LTG_MODE_ENV: begin
            // RQ10 envelope high only in the run state, from end of setup until burstOn falls
            key_nxt = (state_r == ST_RUN);
         end
         `LTG_MODE_EXT: begin
            // RQ4 square wave sets frequency and duty
            key_nxt = sqPhase_r;
         end
         default: begin
            key_nxt = 1'b0;
         end
      endcase
   end

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         toneKeyInput <= 1'b0;
      end else begin
         toneKeyInput <= key_nxt;
      end
   end
endmodule

//--- logic/ltg_regs.vh
// Constants for the tone keying host controller
`ifndef LTG_REGS_VH
`define LTG_REGS_VH
`define LTG_CLK_MHZ 250
`define LTG_TONE_HZ 22000
`define LTG_HALF_CYC (`LTG_CLK_MHZ * 1000000 / (2 * `LTG_TONE_HZ))
`define LTG_SETUP_NS 1000
`define LTG_SETUP_CYC ((`LTG_SETUP_NS * `LTG_CLK_MHZ + 999) / 1000)
`define LTG_TAIL_US 60
`define LTG_TAIL_CYC (`LTG_TAIL_US * `LTG_CLK_MHZ)
`define LTG_MODE_OFF 2'h0
`define LTG_MODE_CONT 2'h1
`define LTG_MODE_ENV 2'h2
`define LTG_MODE_EXT 2'h3
`endif

//--- logic/ltg_divider.v
// Enable pulse divider producing one pulse every DIV cycles
`timescale 1ns/1ps
module ltg_divider #(
   parameter DIV = 5681
) (
   input wire clk,
   input wire sys_rst,
   input wire run,
   output reg tick
);
   reg [15:0] cnt_r;
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r <= 16'h0000;
         tick <= 1'b0;
      end else if (!run) begin
         cnt_r <= 16'h0000;
         tick <= 1'b0;
      end else if (cnt_r == DIV - 1) begin
         cnt_r <= 16'h0000;
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule

//--- bench/ltg_dev_model.sv
// Behavioural device side gating the tone from the mode bits and key input
`timescale 1ns/1ps
module ltg_dev_model #(parameter TAIL = 20, parameter SS = 4) (
   input wire clk,
   input wire uv,
   input wire ext,
   input wire tone_enable_bit,
   input wire key,
   output reg toneOn
);
   reg kq = 1'b0;
   reg [7:0] idle = 8'hff;
   reg [7:0] ssCnt = 8'h00;
   always @(posedge clk) begin
      kq <= key;
      idle <= key != kq ? 8'h0 : idle + (idle != 8'hff);
      ssCnt <= uv ? 8'h00 : ssCnt + (ssCnt != 8'hff);
      toneOn <= !uv && ssCnt >= SS && tone_enable_bit && (ext ? idle < TAIL : key);
   end
endmodule

//--- bench/ltg_host_ctrl_assertions.sv
// Port checks of the tone keying host controller
`timescale 1ns/1ps
module ltg_chk #(parameter HALF_CYC = 4, parameter TAIL_CYC = 20) (
   input wire clk,
   input wire sys_rst,
   input wire [1:0] modeReq,
   input wire modeLoad,
   input wire burstOn,
   input wire underVoltage,
   input wire busy,
   input wire externalWaveformSelect,
   input wire toneEnableBit,
   input wire toneKeyInput
);
   reg [2:0] uvH;
   wire e = externalWaveformSelect;
   wire t = toneEnableBit;
   wire ok = uvH == 3'h0 && !underVoltage && modeLoad && !busy;
   always @(posedge clk or posedge sys_rst)
      if (sys_rst) uvH <= 3'h7;
      else uvH <= {uvH[1:0], underVoltage};
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_ext; ok && modeReq == 2'h3 |=> e && t; endproperty
   a_ext: assert property (p_ext) else $error("ext load");
   property p_env; ok && modeReq == 2'h2 |=> !e && t; endproperty
   a_env: assert property (p_env) else $error("env load");
   property p_off; ok && modeReq == 2'h0 |=> !e && !t; endproperty
   a_off: assert property (p_off) else $error("off load");
   property p_uv; uvH == 3'h7 && underVoltage |-> !e && !t; endproperty
   a_uv: assert property (p_uv) else $error("lockout bits");
   property p_key; $rose(toneKeyInput) && e |-> t; endproperty
   a_key: assert property (p_key) else $error("wave early");
   property p_half; $changed(toneKeyInput) && e && busy |=> $stable(toneKeyInput)[*3]; endproperty
   a_half: assert property (p_half) else $error("half period");
   property p_setup; $rose(busy) |-> !toneKeyInput[*8]; endproperty
   a_setup: assert property (p_setup) else $error("setup gap");
   property p_tail; $fell(burstOn) && busy |=> busy[*8]; endproperty
   a_tail: assert property (p_tail) else $error("tail short");
   c_ext: cover property ($rose(busy) && e);
   c_env: cover property ($rose(busy) && !e);
   c_uv: cover property (underVoltage && t);
endmodule
bind ltg_host_ctrl ltg_chk #(.HALF_CYC(HALF_CYC), .TAIL_CYC(TAIL_CYC)) u_chk(.clk(clk), .sys_rst(sys_rst),
   .modeReq(modeReq), .modeLoad(modeLoad), .burstOn(burstOn), .underVoltage(underVoltage), .busy(busy),
   .externalWaveformSelect(externalWaveformSelect), .toneEnableBit(toneEnableBit), .toneKeyInput(toneKeyInput));

//--- bench/tb_top.sv
// Bench for the tone keying host controller
`timescale 1ns/1ps
module tb_top;
   reg clk = 0, sys_rst = 1, modeLoad = 0, burstOn = 0, underVoltage = 0;
   reg [1:0] modeReq = 2'h0;
   reg [31:0] lfsr = 32'h7bb452bd;
   wire busy, ext, tone_enable_bit, key, toneOn;
   reg [2:0] expQ[$];
   integer err_total = 0, tests_run = 0, i;
   event look;
   ltg_host_ctrl #(.HALF_CYC(4), .TAIL_CYC(20)) i_dut(.clk(clk), .sys_rst(sys_rst), .modeReq(modeReq),
      .modeLoad(modeLoad), .burstOn(burstOn), .underVoltage(underVoltage), .busy(busy),
      .externalWaveformSelect(ext), .toneEnableBit(tone_enable_bit), .toneKeyInput(key));
   ltg_dev_model #(.TAIL(20)) i_dev(.clk(clk), .uv(underVoltage), .ext(ext), .tone_enable_bit(tone_enable_bit), .key(key), .toneOn(toneOn));
   initial forever #2 clk = ~clk;
   task cmp(input [2:0] seen, input [2:0] want);
      begin
         tests_run = tests_run + 1;
         if (seen !== want) begin
            err_total = err_total + 1;
            $display("CHECK FAILED ext/ten/tone exp %h seen %h", want, seen);
         end
      end
   endtask
   function [31:0] lfsr_next(input [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task close_out;
      begin
         if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task note(input [2:0] e);
      begin
         expQ.push_back(e);
         ->look;
         tick(1);
      end
   endtask
   task load(input [1:0] m);
      begin
         modeReq = m;
         modeLoad = 1;
         tick(1);
         modeLoad = 0;
         tick(3);
      end
   endtask
   task burst(input [2:0] on);
      begin
         burstOn = 1;
         tick(300);
         lfsr = lfsr_next(lfsr);
         load(lfsr[1:0]);
         note(on);
         burstOn = 0;
         for (i = 0; i < 100 && busy !== 1'b0; i = i + 1) tick(1);
         // Device stop delay equals the tail, so allow a few more cycles
         tick(6);
         note(on & 3'h6);
      end
   endtask
   // Oldest expectation against what the outputs show now
   always @(look) cmp({ext, tone_enable_bit, toneOn}, expQ.pop_front());
   initial begin
      #20000;
      err_total = err_total + 1;
      close_out;
   end
   initial begin
      tick(16);
      sys_rst = 0;
      tick(3);
      note(3'h0);
      load(2'h0);
      note(3'h0);
      load(2'h1);
      note(3'h3);
      load(2'h3);
      burst(3'h7);
      load(2'h2);
      burst(3'h3);
      underVoltage = 1;
      tick(6);
      note(3'h0);
      underVoltage = 0;
      tick(3);
      load(2'h1);
      note(3'h3);
      close_out;
   end
endmodule
